// *** regbank_pkg.sv ***
// constants for the buck-boost configuration and status register bank
// Functional notes
// - unimplemented bits ignore writes, read zero
// - target high nibble bits 3:0, reset 0x2
// - step 20mV or 10mV per divider select
// - target low byte bits 7:0, reset 0x58
// - live constant-current flag on bit 6
// - fault byte: busy bit7, off bit6
// - overvoltage bit5, overcurrent bit4, undervoltage bit3
// - temperature bit2, comm bit1, other bit0
// - power control: discharge bit1, enable bit0
// - config zero enable bit0, reset 0x32
// - config zero bit6 negative current limit
// - config zero bit5 auxiliary regulator enable
// - config zero bit4 current monitor limiter
// - config zero bit3 hiccup protection enable
// - config zero bit2 dual spread spectrum
// - config zero bit1 micro sleep enable
// - config one thermal warning enable, level
// - config one bit4 fault pin interrupt mode
// - config one bit3 tracking direct startup
// - config one bit2 bias supply priority
// - config one bit1 two-phase forced PWM
// - config one bit0 two-phase save, reset 0x09
package regbank_pkg;
    localparam logic [7:0] ADDR_TARGET_LOW   = 8'h0C;
    localparam logic [7:0] ADDR_TARGET_HIGH  = 8'h0D;
    localparam logic [7:0] ADDR_CL_STATUS    = 8'h21;
    localparam logic [7:0] ADDR_FAULT_SUM    = 8'h78;
    localparam logic [7:0] ADDR_POWER_CTRL   = 8'h81;
    localparam logic [7:0] ADDR_CONFIG_ZERO  = 8'hD0;
    localparam logic [7:0] ADDR_CONFIG_ONE   = 8'hD1;
    localparam logic [7:0] RST_TARGET_LOW    = 8'h58;
    localparam logic [3:0] RST_TARGET_HIGH   = 4'h2;
    localparam logic [1:0] RST_POWER_CTRL    = 2'h1;
    localparam logic [6:0] RST_CONFIG_ZERO   = 7'h32;
    localparam logic [7:0] RST_CONFIG_ONE    = 8'h09;
    localparam logic [3:0] MASK_TARGET_HIGH  = 4'hF;
    localparam int         CC_BIT            = 6;
    localparam int         PC_DISCH_BIT      = 1;
    localparam int         PC_EN_BIT         = 0;
endpackage : regbank_pkg

// *** buck_boost_config_status_regs.sv ***
// register bank of the buck-boost controller, host access by address
`timescale 1ns/1ns
module buck_boost_config_status_regs
    import regbank_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata,
    output logic             addr_hit,
    input  wire logic        constant_current_active,
    input  wire logic        busy_in,
    input  wire logic        unit_off_in,
    input  wire logic        output_overvoltage_fault,
    input  wire logic        output_overcurrent_fault,
    input  wire logic        input_undervoltage_fault,
    input  wire logic        temperature_fault,
    input  wire logic        comm_logic_memory_flag,
    input  wire logic        other_fault,
    output logic      [11:0] output_target_code,
    output logic             force_output_discharge,
    output logic             power_stage_enable_b,
    output logic             power_stage_enable_a,
    output logic             negative_limit_enable,
    output logic             aux_regulator_enable,
    output logic             monitor_limiter_enable,
    output logic             hiccup_enable,
    output logic             dual_spread_enable,
    output logic             micro_sleep_enable,
    output logic             thermal_warning_enable,
    output logic      [1:0]  thermal_warning_level,
    output logic             fault_pin_interrupt_mode,
    output logic             tracking_direct_startup,
    output logic             bias_supply_priority,
    output logic             two_phase_forced_enable,
    output logic             two_phase_save_enable
);
    import regbank_pkg::*;

    // status inputs come from the analog side: two-stage synchronisers
    logic [7:0] stat_meta_q;
    logic [7:0] stat_sync_q;
    logic [7:0] stat_raw;
    logic [7:0] tlow_q;
    logic [3:0] thigh_q;
    logic [1:0] pctrl_q;
    logic [6:0] cfg0_q;
    logic [7:0] cfg1_q;
    logic [7:0] rdata_d;
    logic       hit_d;
    logic       cc_meta_q;
    logic       cc_sync_q;

    assign stat_raw = {busy_in, unit_off_in, output_overvoltage_fault,
                       output_overcurrent_fault, input_undervoltage_fault,
                       temperature_fault, comm_logic_memory_flag, other_fault};

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stat_meta_q <= 8'h00;
            stat_sync_q <= 8'h00;
            cc_meta_q   <= 1'b0;
            cc_sync_q   <= 1'b0;
        end else begin
            stat_meta_q <= stat_raw;
            stat_sync_q <= stat_meta_q;
            cc_meta_q   <= constant_current_active;
            cc_sync_q   <= cc_meta_q;
        end
    end

    wire w_tlow  = wr_en && (addr == ADDR_TARGET_LOW);
    wire w_thigh = wr_en && (addr == ADDR_TARGET_HIGH);
    wire w_pctrl = wr_en && (addr == ADDR_POWER_CTRL);
    wire w_cfg0  = wr_en && (addr == ADDR_CONFIG_ZERO);
    wire w_cfg1  = wr_en && (addr == ADDR_CONFIG_ONE);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tlow_q  <= RST_TARGET_LOW;
            thigh_q <= RST_TARGET_HIGH;
            pctrl_q <= RST_POWER_CTRL;
            cfg0_q  <= RST_CONFIG_ZERO;
            cfg1_q  <= RST_CONFIG_ONE;
        end else begin
            if (w_tlow)  tlow_q  <= wdata;
            if (w_thigh) thigh_q <= wdata[3:0] & MASK_TARGET_HIGH;
            if (w_pctrl) pctrl_q <= wdata[1:0];
            if (w_cfg0)  cfg0_q  <= wdata[6:0];
            if (w_cfg1)  cfg1_q  <= wdata;
        end
    end

    // read decode; unmapped addresses answer zero with addr_hit low
    always_comb begin
        rdata_d = 8'h00;
        hit_d   = 1'b1;
        if (addr == ADDR_TARGET_LOW) begin
            rdata_d = tlow_q;
        end else if (addr == ADDR_TARGET_HIGH) begin
            rdata_d = {4'h0, thigh_q};
        end else if (addr == ADDR_CL_STATUS) begin
            rdata_d[CC_BIT] = cc_sync_q;
        end else if (addr == ADDR_FAULT_SUM) begin
            rdata_d = stat_sync_q;
        end else if (addr == ADDR_POWER_CTRL) begin
            rdata_d = {6'h00, pctrl_q};
        end else if (addr == ADDR_CONFIG_ZERO) begin
            rdata_d = {1'b0, cfg0_q};
        end else if (addr == ADDR_CONFIG_ONE) begin
            rdata_d = cfg1_q;
        end else begin
            hit_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata    <= 8'h00;
            addr_hit <= 1'b0;
        end else if (rd_en) begin
            rdata    <= rdata_d;
            addr_hit <= hit_d;
        end
    end

    // code scale (20mV or 10mV) is applied by the analog divider select
    assign output_target_code       = {thigh_q, tlow_q};
    assign force_output_discharge   = pctrl_q[PC_DISCH_BIT];
    assign power_stage_enable_b     = pctrl_q[PC_EN_BIT];
    assign power_stage_enable_a     = cfg0_q[0];
    assign micro_sleep_enable       = cfg0_q[1];
    assign dual_spread_enable       = cfg0_q[2];
    assign hiccup_enable            = cfg0_q[3];
    assign monitor_limiter_enable   = cfg0_q[4];
    assign aux_regulator_enable     = cfg0_q[5];
    assign negative_limit_enable    = cfg0_q[6];
    assign two_phase_save_enable    = cfg1_q[0];
    assign two_phase_forced_enable  = cfg1_q[1];
    assign bias_supply_priority     = cfg1_q[2];
    assign tracking_direct_startup  = cfg1_q[3];
    assign fault_pin_interrupt_mode = cfg1_q[4];
    assign thermal_warning_level    = cfg1_q[6:5];
    assign thermal_warning_enable   = cfg1_q[7];
endmodule : buck_boost_config_status_regs

// *** regbank_check_asserts.sv ***
// concurrent checks on the register bank ports
`timescale 1ns/1ns
module regbank_check (
    input wire logic mclk, sys_rst, wr_en, rd_en, addr_hit, force_output_discharge,
    input wire logic power_stage_enable_b, two_phase_save_enable,
    input wire logic [7:0] addr, wdata, rdata,
    input wire logic [11:0] output_target_code,
    input wire logic [1:0] thermal_warning_level,
    input wire logic power_stage_enable_a, micro_sleep_enable, dual_spread_enable,
    input wire logic hiccup_enable, monitor_limiter_enable, aux_regulator_enable,
    input wire logic negative_limit_enable, two_phase_forced_enable, bias_supply_priority,
    input wire logic tracking_direct_startup, fault_pin_interrupt_mode,
    input wire logic thermal_warning_enable
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    reset_values_a: assert property ($fell(sys_rst) |-> output_target_code == 12'h258
        && power_stage_enable_b && !force_output_discharge && two_phase_save_enable)
        else $error("reset values");
    high_write_a: assert property (wr_en && addr == 8'h0D |=>
        output_target_code[11:8] == $past(wdata[3:0])) else $error("high nibble");
    low_write_a: assert property (wr_en && addr == 8'h0C |=>
        output_target_code[7:0] == $past(wdata)) else $error("low byte");
    power_write_a: assert property (wr_en && addr == 8'h81 |=>
        {force_output_discharge, power_stage_enable_b} == $past(wdata[1:0])) else $error("pwr");
    level_write_a: assert property (wr_en && addr == 8'hD1 |=>
        thermal_warning_level == $past(wdata[6:5])) else $error("warn level");
    upper_zero_a: assert property (rd_en && addr == 8'h0D |=>
        addr_hit && rdata[7:4] == 4'h0) else $error("upper bits");
    power_zero_a: assert property (rd_en && addr == 8'h81 |=>
        addr_hit && rdata[7:2] == 6'h00) else $error("power bits");
    unmapped_read_a: assert property (rd_en && addr == 8'h55 |=>
        !addr_hit && rdata == 8'h00) else $error("unmapped");
    status_mask_a: assert property (rd_en && addr == 8'h21 |=>
        rdata[7] == 1'b0 && rdata[5:0] == 6'h00) else $error("status mask");
    config_zero_write_a: assert property (wr_en && addr == 8'hD0 |=>
        {negative_limit_enable, aux_regulator_enable, monitor_limiter_enable, hiccup_enable,
         dual_spread_enable, micro_sleep_enable, power_stage_enable_a} == $past(wdata[6:0]))
        else $error("config zero fields");
    config_one_write_a: assert property (wr_en && addr == 8'hD1 |=>
        {thermal_warning_enable, fault_pin_interrupt_mode, tracking_direct_startup,
         bias_supply_priority, two_phase_forced_enable, two_phase_save_enable}
        == {$past(wdata[7]), $past(wdata[4:0])}) else $error("config one fields");
endmodule : regbank_check

// *** status_source.sv ***
// far-side model: status levels from the converter core
`timescale 1ns/1ns
module status_source (
    input  wire logic       mclk,
    input  wire logic [8:0] flags_req,
    output logic      [8:0] flags
);
    initial flags = 9'h000;
    always @(negedge mclk) flags <= flags_req;
endmodule : status_source

// *** buck_boost_config_status_regs_test.sv ***
// self-checking bench for the register bank
`timescale 1ns/1ns
module buck_boost_config_status_regs_test;
    import regbank_pkg::*;
    logic mclk = 0, sys_rst = 1, wr_en = 0, rd_en = 0, addr_hit;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [8:0] flags_req = 9'h000, flags;
    logic [1:0] lvl;
    int n_mismatch = 0, samples_checked = 0;
    logic [7:0] adr [7] = '{ADDR_TARGET_LOW, ADDR_TARGET_HIGH, ADDR_CL_STATUS, ADDR_FAULT_SUM,
        ADDR_POWER_CTRL, ADDR_CONFIG_ZERO, ADDR_CONFIG_ONE};
    logic [7:0] rstv [7] = '{8'h58, 8'h02, 8'h00, 8'h00, 8'h01, 8'h32, 8'h09};
    logic [7:0] mask [7] = '{8'hFF, 8'h0F, 8'h00, 8'h00, 8'h03, 8'h7F, 8'hFF};
    status_source status_source_inst (.mclk, .flags_req, .flags);
    buck_boost_config_status_regs buck_boost_config_status_regs_inst (.mclk, .sys_rst, .wr_en,
        .rd_en, .addr, .wdata, .rdata, .addr_hit, .constant_current_active(flags[8]),
        .busy_in(flags[7]), .unit_off_in(flags[6]), .output_overvoltage_fault(flags[5]),
        .output_overcurrent_fault(flags[4]), .input_undervoltage_fault(flags[3]),
        .temperature_fault(flags[2]), .comm_logic_memory_flag(flags[1]), .other_fault(flags[0]),
        .output_target_code(), .force_output_discharge(), .power_stage_enable_b(),
        .power_stage_enable_a(), .negative_limit_enable(), .aux_regulator_enable(),
        .monitor_limiter_enable(), .hiccup_enable(), .dual_spread_enable(),
        .micro_sleep_enable(), .thermal_warning_enable(), .thermal_warning_level(lvl),
        .fault_pin_interrupt_mode(), .tracking_direct_startup(), .bias_supply_priority(),
        .two_phase_forced_enable(), .two_phase_save_enable());
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge mclk) {wr_en, addr, wdata} = {1'b1, a, d};
        @(negedge mclk) wr_en = 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] exp, logic hit);
        @(negedge mclk) {rd_en, addr} = {1'b1, a};
        @(negedge mclk) rd_en = 1'b0;
        chk("rdata", rdata, exp);
        chk("addr_hit", {7'h00, addr_hit}, {7'h00, hit});
    endtask : rd
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    initial forever #10 mclk = ~mclk;
    initial begin
        repeat (6) @(negedge mclk);
        sys_rst = 1'b0;
        for (int i = 0; i < 7; i++) rd(adr[i], rstv[i], 1'b1);
        for (int i = 0; i < 7; i++) wr(adr[i], 8'hFF);
        for (int i = 0; i < 7; i++) rd(adr[i], mask[i], 1'b1);
        for (int i = 0; i < 7; i++) wr(adr[i], 8'h00);
        for (int i = 0; i < 7; i++) rd(adr[i], 8'h00, 1'b1);
        for (int v = 0; v < 4; v++) begin
            wr(ADDR_CONFIG_ONE, {1'b1, v[1:0], 5'h00});
            chk("warn_level", {6'h00, lvl}, v[7:0]);
        end
        for (int b = 0; b < 9; b++) begin
            flags_req = 9'h001 << b;
            repeat (3) @(negedge mclk);
            rd(b == 8 ? ADDR_CL_STATUS : ADDR_FAULT_SUM, b == 8 ? 8'h40 : 8'h01 << b, 1'b1);
        end
        flags_req = 9'h000;
        wr(8'h55, 8'hFF);
        rd(8'h55, 8'h00, 1'b0);
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        rd(ADDR_CONFIG_ZERO, 8'h32, 1'b1);
        report_and_stop();
    end
endmodule : buck_boost_config_status_regs_test
bind buck_boost_config_status_regs regbank_check regbank_check_inst (.*);
